/* bench/rlcs_host.sv */
// Behavioural host on the serial link, seen as receive events
`timescale 1ns/1ps
module rlcs_host (
    // Clock
    input wire logic pclk,
    // Events towards one port
    output rlcs_pkg::rlcs_evt_t evt
);
    import rlcs_pkg::*;
    initial begin
        evt = '0;
        evt.line_idle = 1'b1;
        evt.link_run = 1'b1;
        evt.link_freq = 1'b1;
    end

    // Line busy for a few characters, then one end-of-request pulse
    task automatic request(input logic [7:0] a, input logic bad);
        @(posedge pclk);
        evt.line_idle <= 1'b0;
        repeat (3) @(posedge pclk);
        evt.req_done <= 1'b1;
        evt.req_addr <= a;
        evt.req_bad <= bad;
        @(posedge pclk);
        evt.req_done <= 1'b0;
        evt.req_bad <= 1'b0;
        evt.line_idle <= 1'b1;
        // Stale address is not left standing
        evt.req_addr <= ~a;
    endtask : request

    task automatic line_error();
        @(posedge pclk);
        evt.line_err <= 1'b1;
        @(posedge pclk);
        evt.line_err <= 1'b0;
    endtask : line_error
endmodule : rlcs_host

/* bench/rlcs_properties.sv */
// Concurrent checks on the link supervisor's top-level ports
`timescale 1ns/1ps
module rlcs_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Drive and ports
    input wire logic drive_running,
    input rlcs_pkg::rlcs_evt_t evt_a,
    input rlcs_pkg::rlcs_out_t port_a,
    input rlcs_pkg::rlcs_out_t port_b,
    input wire logic alarm_stop
);
    import rlcs_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    sequence clear_s;
        psel && penable && pready && pwrite && paddr == 8'h2c && pwdata[0];
    endsequence

    a_one_wait: assert property (setup_s ##1 access_s |=> pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_bad_address: assert property (psel && penable && pready && (paddr[7]
        || paddr[1:0] != 2'h0 || paddr[5:2] > IDX_CONTROL) |-> pslverr)
        else $error("unmapped access not refused");
    a_alarm_stop: assert property (alarm_stop == $past(port_a.alarm || port_b.alarm))
        else $error("alarm stop does not follow port alarms");
    a_exec_cause: assert property (port_a.exec |-> $past(evt_a.req_done && !evt_a.req_bad))
        else $error("execute without clean request");
    a_bcast_quiet: assert property (evt_a.req_done && evt_a.req_addr == 8'h00
        |=> !port_a.reply_go [*2]) else $error("reply to broadcast");
    a_run_gate: assert property (!drive_running && !port_a.delaying && !port_a.alarm
        |=> !port_a.alarm) else $error("alarm while drive stopped");
    a_alarm_clear: assert property (clear_s |-> ##[1:3] !port_a.alarm)
        else $error("alarm not cleared");
    a_format_hold: assert property (!evt_a.line_idle |=> $stable({port_a.baud_div,
        port_a.data7, port_a.parity, port_a.two_stop})) else $error("format changed mid character");
endmodule : rlcs_properties

bind rlcs_top rlcs_properties chk (.*);

/* bench/tb.sv */
// Self-checking bench of the link configuration supervisor
`timescale 1ns/1ps
module tb;
    import rlcs_pkg::*;
    localparam int TK = 4;
    logic pclk, presetn, psel, penable, pwrite, drive_running, pready, pslverr, alarm_stop, slv;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    rlcs_evt_t evt_a, evt_b;
    rlcs_out_t port_a, port_b;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [15:0] divs [5] = '{DIV_2400, DIV_4800, DIV_9600, DIV_19200, DIV_38400};
    // {protocol, length, parity, stop, 2'h0, data7, parity, two_stop}
    logic [11:0] fm [5] = '{12'hb0d, 12'h8c2, 12'h241, 12'h304, 12'h602};

    rlcs_top #(.TICK_CYCLES(TK)) DUT (.*);
    rlcs_host host_a (.pclk(pclk), .evt(evt_a));
    rlcs_host host_b (.pclk(pclk), .evt(evt_b));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    // ----
    // Tasks
    // ----
    task automatic test_done();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] ad(input int p, input logic [3:0] i);
        return 8'(p * 64 + i * 4);
    endfunction : ad

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(n < 20), 32'h1);
    endtask : apb

    task automatic wr(input int p, input logic [3:0] i, input logic [31:0] d);
        apb(1'b1, ad(p, i), d);
    endtask : wr

    task automatic rchk(input int p, input logic [3:0] i, input logic [31:0] e);
        apb(1'b0, ad(p, i), 32'h0);
        chk(rd, e);
    endtask : rchk

    // Request on port A (port B if pb), expect {exec, reply} seen within five cycles
    task automatic areq(input logic [7:0] a, input logic bad, input logic [1:0] e,
                        input logic pb = 1'b0);
        logic [1:0] seen;
        seen = 2'h0;
        if (pb) begin
            host_b.request(a, bad);
        end else begin
            host_a.request(a, bad);
        end
        repeat (5) begin
            @(posedge pclk);
            seen = seen | (pb ? {port_b.exec, port_b.reply_go} : {port_a.exec, port_a.reply_go});
        end
        chk(32'(seen), 32'(e));
    endtask : areq

    task automatic setup(input int p, input logic [1:0] pr, input logic [7:0] st);
        wr(p, IDX_PROTOCOL, 32'(pr));
        wr(p, IDX_STATION, 32'(st));
    endtask : setup

    // Status is {silent, delaying, addr_ok, alarm}
    task automatic perr(input logic [1:0] pol, input logic run, input logic rec,
                        input logic [3:0] s1, input logic [3:0] s2);
        wr(0, IDX_POLICY, 32'(pol));
        drive_running <= run;
        host_a.line_error();
        rchk(0, IDX_STATUS, 32'(s1));
        if (rec) begin
            host_a.request(8'h01, 1'b0);
        end
        repeat (60) @(posedge pclk);
        rchk(0, IDX_STATUS, 32'(s2));
        chk(32'(alarm_stop), 32'(s2[0]));
        drive_running <= 1'b0;
        wr(0, IDX_CONTROL, 32'h1);
        rchk(0, IDX_STATUS, 32'h2);
    endtask : perr

    // ----
    // Main sequence
    // ----
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        drive_running = 1'b0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(port_a.baud_div), 32'(DIV_9600));
        for (int i = 0; i < 20; i++) begin
            rchk(i / 10, 4'(i % 10), 32'(i % 10 == 3 ? 2 : (i % 10 == 0 || i % 10 == 8)));
        end
        wr(0, IDX_ERR_TIMER, 32'h3e8);
        rchk(0, IDX_ERR_TIMER, 32'(ERR_TIMER_MAX));
        wr(0, IDX_SILENCE, 32'h3f);
        rchk(0, IDX_SILENCE, 32'(SILENCE_MAX));
        wr(0, IDX_REPLY, 32'hff);
        rchk(0, IDX_REPLY, 32'(REPLY_MAX));
        apb(1'b0, 8'h30, 32'h0);
        chk({rd[30:0], slv}, 32'h1);
        for (int b = 0; b < 5; b++) begin
            wr(0, IDX_BAUD, 32'(b));
            repeat (2) @(posedge pclk);
            chk(32'(port_a.baud_div), 32'(divs[b]));
        end
        // Baud written while a character is in flight must wait for idle
        fork
            host_a.request(8'h07, 1'b0);
            begin
                wr(0, IDX_BAUD, 32'h2);
                repeat (2) @(posedge pclk);
                chk(32'(port_a.baud_div), 32'(DIV_38400));
            end
        join
        repeat (2) @(posedge pclk);
        chk(32'(port_a.baud_div), 32'(DIV_9600));
        for (int k = 0; k < 5; k++) begin
            wr(0, IDX_PROTOCOL, 32'(fm[k][11:10]));
            wr(0, IDX_LENGTH, 32'(fm[k][9]));
            wr(0, IDX_PARITY, 32'(fm[k][8:7]));
            wr(0, IDX_STOP, 32'(fm[k][6]));
            repeat (2) @(posedge pclk);
            chk(32'({port_a.data7, port_a.parity, port_a.two_stop}), 32'(fm[k][3:0]));
        end
        wr(0, IDX_SILENCE, 32'h0);
        wr(0, IDX_REPLY, 32'h0);
        setup(0, PROTO_GENERAL, 8'h05);
        areq(8'h05, 1'b0, 2'h3);
        areq(8'h63, 1'b0, 2'h2);
        areq(8'h06, 1'b0, 2'h0);
        areq(8'h05, 1'b1, 2'h0);
        setup(0, PROTO_GENERAL, 8'h20);
        areq(8'h20, 1'b0, 2'h0);
        setup(0, PROTO_MODBUS, 8'hf7);
        areq(8'hf7, 1'b0, 2'h3);
        areq(8'h00, 1'b0, 2'h2);
        setup(0, PROTO_MODBUS, 8'hf8);
        areq(8'hf8, 1'b0, 2'h0);
        setup(0, PROTO_LOADER, 8'hff);
        areq(8'hff, 1'b0, 2'h3);
        areq(8'h00, 1'b0, 2'h0);
        setup(1, PROTO_LOADER, 8'h01);
        rchk(1, IDX_STATUS, 32'h0);
        wr(1, IDX_PARITY, 32'(PAR_ODD));
        wr(1, IDX_REPLY, 32'h0);
        areq(8'h01, 1'b0, 2'h0, 1'b1);
        chk(32'({port_b.data7, port_b.parity, port_b.two_stop}), 32'h5);
        setup(1, PROTO_MODBUS, 8'h01);
        areq(8'h01, 1'b0, 2'h3, 1'b1);
        setup(0, PROTO_MODBUS, 8'h01);
        wr(0, IDX_REPLY, 32'h2);
        host_a.request(8'h01, 1'b0);
        for (int n = 1; n < 40; n++) begin
            @(posedge pclk);
            if (port_a.reply_go === 1'b1) begin
                chk(32'(n >= 2 * TK - TK && n <= 2 * TK + 4), 32'h1);
                break;
            end
            chk(32'(n < 39), 32'h1);
        end
        wr(0, IDX_ERR_TIMER, 32'h1);
        perr(POL_TRIP, 1'b0, 1'b0, 4'h2, 4'h2);
        perr(POL_IGNORE, 1'b1, 1'b0, 4'h2, 4'h2);
        perr(POL_TRIP, 1'b1, 1'b0, 4'h3, 4'h3);
        perr(POL_DELAY_TRIP, 1'b1, 1'b0, 4'h6, 4'h3);
        perr(POL_RECOVER, 1'b1, 1'b1, 4'h6, 4'h2);
        perr(POL_RECOVER, 1'b1, 1'b0, 4'h6, 4'h3);
        wr(0, IDX_POLICY, 32'(POL_TRIP));
        wr(0, IDX_SILENCE, 32'h1);
        drive_running <= 1'b1;
        host_a.request(8'h01, 1'b0);
        repeat (480) @(posedge pclk);
        rchk(0, IDX_STATUS, 32'hb);
        test_done();
    end
endmodule : tb

/* hdl/rlcs_pkg.sv */
// Shared constants and types of the serial link configuration supervisor
package rlcs_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_W = 20;
    localparam int TICKS_PER_DSEC = 100 / TICK_MS;
    localparam int TICKS_PER_SEC = 1000 / TICK_MS;
    localparam logic [15:0] DIV_2400 = 16'((CLK_HZ + 1200) / 2400);
    localparam logic [15:0] DIV_4800 = 16'((CLK_HZ + 2400) / 4800);
    localparam logic [15:0] DIV_9600 = 16'((CLK_HZ + 4800) / 9600);
    localparam logic [15:0] DIV_19200 = 16'((CLK_HZ + 9600) / 19200);
    localparam logic [15:0] DIV_38400 = 16'((CLK_HZ + 19200) / 38400);

    // ----------------------------------------------------------------
    // Register map (word indices within a port block, port B at +0x40)
    // ----------------------------------------------------------------
    localparam logic [3:0] IDX_STATION = 4'h0;
    localparam logic [3:0] IDX_POLICY = 4'h1;
    localparam logic [3:0] IDX_ERR_TIMER = 4'h2;
    localparam logic [3:0] IDX_BAUD = 4'h3;
    localparam logic [3:0] IDX_LENGTH = 4'h4;
    localparam logic [3:0] IDX_PARITY = 4'h5;
    localparam logic [3:0] IDX_STOP = 4'h6;
    localparam logic [3:0] IDX_SILENCE = 4'h7;
    localparam logic [3:0] IDX_REPLY = 4'h8;
    localparam logic [3:0] IDX_PROTOCOL = 4'h9;
    localparam logic [3:0] IDX_STATUS = 4'ha;
    localparam logic [3:0] IDX_CONTROL = 4'hb;
    localparam int PORT_SEL_BIT = 6;

    // ----------------------------------------------------------------
    // Codes, limits and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] PROTO_MODBUS = 2'h0;
    localparam logic [1:0] PROTO_LOADER = 2'h1;
    localparam logic [1:0] PROTO_GENERAL = 2'h2;
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] POL_TRIP = 2'h0;
    localparam logic [1:0] POL_DELAY_TRIP = 2'h1;
    localparam logic [1:0] POL_RECOVER = 2'h2;
    localparam logic [1:0] POL_IGNORE = 2'h3;
    localparam logic [7:0] MB_ADDR_MAX = 8'hf7;
    localparam logic [7:0] LD_ADDR_MAX = 8'hff;
    localparam logic [7:0] GP_ADDR_MAX = 8'h1f;
    localparam logic [7:0] MB_BCAST = 8'h00;
    localparam logic [7:0] GP_BCAST = 8'h63;
    localparam logic [9:0] ERR_TIMER_MAX = 10'h258;
    localparam logic [5:0] SILENCE_MAX = 6'h3c;
    localparam logic [6:0] REPLY_MAX = 7'h64;
    localparam logic [7:0] RST_STATION = 8'h01;
    localparam logic [2:0] RST_BAUD = 3'h2;
    localparam logic [6:0] RST_REPLY = 7'h01;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {RLCS_IDLE, RLCS_DELAY, RLCS_ALARM} rlcs_state_t;

    typedef struct packed {
        logic [7:0] station;
        logic [1:0] policy;
        logic [9:0] err_timer;
        logic [2:0] baud;
        logic [0:0] length;
        logic [1:0] parity;
        logic [0:0] stop;
        logic [5:0] silence;
        logic [6:0] reply_delay;
        logic [1:0] protocol;
    } rlcs_cfg_t;

    typedef struct packed {
        logic req_done;
        logic [7:0] req_addr;
        logic req_bad;
        logic line_err;
        logic line_idle;
        logic link_run;
        logic link_freq;
    } rlcs_evt_t;

    typedef struct packed {
        logic [15:0] baud_div;
        logic data7;
        logic [1:0] parity;
        logic two_stop;
        logic exec;
        logic reply_go;
        logic alarm;
        logic addr_ok;
        logic delaying;
        logic silent;
    } rlcs_out_t;

endpackage : rlcs_pkg

/* hdl/rlcs_top.sv */
// Serial link configuration supervisor: APB registers and two port supervisors
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port supervisor
// ----------------------------------------------------------------
module rlcs_port #(
    parameter bit IS_B = 1'b0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic tick,
    input wire logic alarm_clr,
    input wire logic drive_running,
    input rlcs_pkg::rlcs_cfg_t cfg,
    input rlcs_pkg::rlcs_evt_t evt,
    // Result
    output rlcs_pkg::rlcs_out_t outp
);
    import rlcs_pkg::*;

    typedef struct packed {
        rlcs_out_t o;
        rlcs_state_t st;
        logic [12:0] err_cnt;
        logic [12:0] sil_cnt;
        logic [6:0] reply_cnt;
        logic reply_pend;
        logic recovered;
    } rlcs_port_state_t;

    rlcs_port_state_t q_r;
    rlcs_port_state_t q_nxt;

    logic link_active;
    logic loader_ok;
    logic addr_ok;
    logic bcast;
    logic hit;
    logic good_req;
    logic [12:0] sil_lim;
    logic [12:0] err_lim;
    logic sil_err;
    logic err_evt;

    always_comb begin
        q_nxt = q_r;
        q_nxt.o.exec = 1'b0;
        q_nxt.o.reply_go = 1'b0;
        link_active = drive_running & evt.link_run & evt.link_freq;
        loader_ok = !IS_B;
        // Address window per protocol; an unknown protocol never answers
        case (cfg.protocol)
            PROTO_MODBUS: begin
                addr_ok = (cfg.station != 8'h00) && (cfg.station <= MB_ADDR_MAX);
                bcast = (evt.req_addr == MB_BCAST);
            end
            PROTO_LOADER: begin
                addr_ok = loader_ok && (cfg.station != 8'h00)
                    && (cfg.station <= LD_ADDR_MAX);
                bcast = 1'b0;
            end
            PROTO_GENERAL: begin
                addr_ok = (cfg.station != 8'h00) && (cfg.station <= GP_ADDR_MAX);
                bcast = (evt.req_addr == GP_BCAST);
            end
            default: begin
                addr_ok = 1'b0;
                bcast = 1'b0;
            end
        endcase
        q_nxt.o.addr_ok = addr_ok;
        hit = (evt.req_addr == cfg.station);
        // Damaged requests are dropped without answer and do not count as access
        good_req = evt.req_done && !evt.req_bad && addr_ok && (hit || bcast);

        // Line format only moves while the line is idle
        if (evt.line_idle) begin
            case (cfg.baud)
                3'h0: q_nxt.o.baud_div = DIV_2400;
                3'h1: q_nxt.o.baud_div = DIV_4800;
                3'h2: q_nxt.o.baud_div = DIV_9600;
                3'h3: q_nxt.o.baud_div = DIV_19200;
                3'h4: q_nxt.o.baud_div = DIV_38400;
                default: q_nxt.o.baud_div = DIV_9600;
            endcase
            q_nxt.o.data7 = cfg.length[0];
            q_nxt.o.parity = (cfg.parity == PAR_ODD) ? PAR_ODD
                : (cfg.parity == PAR_EVEN) ? PAR_EVEN : PAR_NONE;
            q_nxt.o.two_stop = !cfg.stop[0];
            if (cfg.protocol == PROTO_MODBUS) begin
                q_nxt.o.data7 = 1'b0;
                // Eleven bit character: missing parity bit becomes a second stop
                q_nxt.o.two_stop = (q_nxt.o.parity == PAR_NONE);
            end else if (cfg.protocol == PROTO_LOADER && loader_ok) begin
                q_nxt.o.data7 = 1'b0;
                q_nxt.o.parity = PAR_EVEN;
                q_nxt.o.two_stop = 1'b0;
            end
        end

        // Accepted request: execute, and answer only if addressed directly
        if (good_req) begin
            q_nxt.o.exec = 1'b1;
            q_nxt.recovered = 1'b1;
            if (!bcast) begin
                q_nxt.reply_pend = 1'b1;
                q_nxt.reply_cnt = cfg.reply_delay;
            end
        end else if (q_r.reply_pend) begin
            // Delay granularity is one tick; zero fires next cycle
            if (q_r.reply_cnt == 7'h00) begin
                q_nxt.o.reply_go = 1'b1;
                q_nxt.reply_pend = 1'b0;
            end else if (tick) begin
                q_nxt.reply_cnt = q_r.reply_cnt - 7'h01;
            end
        end

        // Silence watchdog
        sil_lim = 13'(cfg.silence * TICKS_PER_SEC);
        sil_err = 1'b0;
        if (cfg.silence == 6'h00 || good_req) begin
            q_nxt.sil_cnt = 13'h0000;
        end else if (tick && q_r.sil_cnt < sil_lim) begin
            q_nxt.sil_cnt = q_r.sil_cnt + 13'h0001;
            sil_err = (q_nxt.sil_cnt == sil_lim);
        end
        q_nxt.o.silent = (cfg.silence != 6'h00) && (q_r.sil_cnt == sil_lim);

        err_evt = (evt.line_err | sil_err) & link_active;
        err_lim = 13'(cfg.err_timer * TICKS_PER_DSEC);

        // Error policy
        case (q_r.st)
            RLCS_IDLE: begin
                if (err_evt) begin
                    case (cfg.policy)
                        POL_TRIP: begin
                            q_nxt.st = RLCS_ALARM;
                            q_nxt.o.alarm = 1'b1;
                        end
                        POL_DELAY_TRIP, POL_RECOVER: begin
                            q_nxt.st = RLCS_DELAY;
                            q_nxt.err_cnt = 13'h0000;
                            q_nxt.recovered = 1'b0;
                        end
                        default: q_nxt.st = RLCS_IDLE;
                    endcase
                end
            end
            RLCS_DELAY: begin
                if (q_r.err_cnt >= err_lim) begin
                    if (cfg.policy == POL_RECOVER && q_r.recovered) begin
                        q_nxt.st = RLCS_IDLE;
                    end else begin
                        q_nxt.st = RLCS_ALARM;
                        q_nxt.o.alarm = 1'b1;
                    end
                end else if (tick) begin
                    q_nxt.err_cnt = q_r.err_cnt + 13'h0001;
                end
            end
            RLCS_ALARM: begin
                // Sticky until software clears; new errors meanwhile add nothing
                if (alarm_clr) begin
                    q_nxt.st = RLCS_IDLE;
                    q_nxt.o.alarm = 1'b0;
                end
            end
            default: q_nxt.st = RLCS_IDLE;
        endcase
        q_nxt.o.delaying = (q_nxt.st == RLCS_DELAY);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= '0;
            q_r.o.baud_div <= DIV_9600;
            q_r.st <= RLCS_IDLE;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign outp = q_r.o;

endmodule : rlcs_port

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module rlcs_top #(
    parameter int TICK_CYCLES = rlcs_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive and port events
    input wire logic drive_running,
    input rlcs_pkg::rlcs_evt_t evt_a,
    input rlcs_pkg::rlcs_evt_t evt_b,
    // Port results
    output rlcs_pkg::rlcs_out_t port_a,
    output rlcs_pkg::rlcs_out_t port_b,
    output logic alarm_stop
);
    import rlcs_pkg::*;

    typedef struct packed {
        rlcs_cfg_t [1:0] cfg;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic alarm_stop;
        logic [1:0] clr;
        logic [TICK_W-1:0] tick_cnt;
        logic tick;
    } rlcs_top_state_t;

    rlcs_top_state_t q_r;
    rlcs_top_state_t q_nxt;
    rlcs_out_t [1:0] pout;

    logic sel_b;
    logic [3:0] idx;
    logic mapped;
    logic [31:0] rd;
    rlcs_cfg_t c;
    rlcs_out_t po;

    always_comb begin
        q_nxt = q_r;
        q_nxt.clr = 2'b00;
        // Time base
        q_nxt.tick = 1'b0;
        if (q_r.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
            q_nxt.tick_cnt = '0;
            q_nxt.tick = 1'b1;
        end else begin
            q_nxt.tick_cnt = q_r.tick_cnt + 1'b1;
        end

        sel_b = paddr[PORT_SEL_BIT];
        idx = paddr[5:2];
        mapped = (paddr[7] == 1'b0) && (paddr[1:0] == 2'b00) && (idx <= IDX_CONTROL);
        c = q_r.cfg[sel_b];
        po = pout[sel_b];
        case (idx)
            IDX_STATION: rd = {24'h000000, c.station};
            IDX_POLICY: rd = {30'h00000000, c.policy};
            IDX_ERR_TIMER: rd = {22'h000000, c.err_timer};
            IDX_BAUD: rd = {29'h00000000, c.baud};
            IDX_LENGTH: rd = {31'h00000000, c.length};
            IDX_PARITY: rd = {30'h00000000, c.parity};
            IDX_STOP: rd = {31'h00000000, c.stop};
            IDX_SILENCE: rd = {26'h0000000, c.silence};
            IDX_REPLY: rd = {25'h0000000, c.reply_delay};
            IDX_PROTOCOL: rd = {30'h00000000, c.protocol};
            IDX_STATUS: rd = {28'h0000000, po.silent, po.delaying, po.addr_ok, po.alarm};
            default: rd = 32'h00000000;
        endcase

        // One wait state: answer prepared in first access cycle
        if (psel && penable && !q_r.pready) begin
            q_nxt.pready = 1'b1;
            q_nxt.pslverr = !mapped;
            q_nxt.prdata = (!pwrite && mapped) ? rd : 32'h00000000;
        end else begin
            q_nxt.pready = 1'b0;
            q_nxt.pslverr = 1'b0;
        end

        if (psel && penable && q_r.pready && pwrite && mapped) begin
            // Out of range error timer, silence and reply values saturate at the documented maximum
            case (idx)
                IDX_STATION: c.station = pwdata[7:0];
                IDX_POLICY: c.policy = pwdata[1:0];
                IDX_ERR_TIMER: c.err_timer = (pwdata[15:0] > 16'(ERR_TIMER_MAX))
                    ? ERR_TIMER_MAX : pwdata[9:0];
                IDX_BAUD: c.baud = pwdata[2:0];
                IDX_LENGTH: c.length = pwdata[0:0];
                IDX_PARITY: c.parity = pwdata[1:0];
                IDX_STOP: c.stop = pwdata[0:0];
                IDX_SILENCE: c.silence = (pwdata[15:0] > 16'(SILENCE_MAX))
                    ? SILENCE_MAX : pwdata[5:0];
                IDX_REPLY: c.reply_delay = (pwdata[15:0] > 16'(REPLY_MAX))
                    ? REPLY_MAX : pwdata[6:0];
                IDX_PROTOCOL: c.protocol = pwdata[1:0];
                IDX_CONTROL: q_nxt.clr[sel_b] = pwdata[0];
                default: c.station = c.station;
            endcase
            q_nxt.cfg[sel_b] = c;
        end

        q_nxt.alarm_stop = pout[0].alarm | pout[1].alarm;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= '0;
            q_r.cfg[0].station <= RST_STATION;
            q_r.cfg[1].station <= RST_STATION;
            q_r.cfg[0].baud <= RST_BAUD;
            q_r.cfg[1].baud <= RST_BAUD;
            q_r.cfg[0].reply_delay <= RST_REPLY;
            q_r.cfg[1].reply_delay <= RST_REPLY;
        end else begin
            q_r <= q_nxt;
        end
    end

    rlcs_port #(.IS_B(1'b0)) u_port_a (
        .pclk(pclk),
        .presetn(presetn),
        .tick(q_r.tick),
        .alarm_clr(q_r.clr[0]),
        .drive_running(drive_running),
        .cfg(q_r.cfg[0]),
        .evt(evt_a),
        .outp(pout[0])
    );

    rlcs_port #(.IS_B(1'b1)) u_port_b (
        .pclk(pclk),
        .presetn(presetn),
        .tick(q_r.tick),
        .alarm_clr(q_r.clr[1]),
        .drive_running(drive_running),
        .cfg(q_r.cfg[1]),
        .evt(evt_b),
        .outp(pout[1])
    );

    assign prdata = q_r.prdata;
    assign pready = q_r.pready;
    assign pslverr = q_r.pslverr;
    assign alarm_stop = q_r.alarm_stop;
    assign port_a = pout[0];
    assign port_b = pout[1];

endmodule : rlcs_top
